// *** common/udirq_params.svh ***
// Constants for the device interrupt status word block
// Functional notes
// RULE_01: Set stall flag, bit 7, when a STALL handshake was sent.
// RULE_02: Set resume flag, bit 5, after K-state persists 2.5 us.
// RULE_03: K-state is differential one at low speed, zero at full speed.
// RULE_04: Set idle flag, bit 4, after 3 ms of continuous Idle; code counts LINE_J only, which is the K-state at low speed.
// RULE_05: Set token-done flag, bit 3, when current token processing ends.
// RULE_06: Clearing token-done advances the transfer status FIFO.
// RULE_07: Set frame-start flag, bit 2, on SOF token or host threshold.
// RULE_08: Error summary, bit 1, read-only, set only by enabled errors.
// RULE_09: Set bus reset flag, bit 0, after reset lasts 2.5 us.
// RULE_10: Bus reset flag not reasserted until bus reset ends.
// RULE_11: Writing one clears a flag; writing zero leaves it.
// RULE_12: Software clears with whole-word writes only, no read-modify-write.
// RULE_13: Bits 15..8 and bit 6 read as zero.
// RULE_14: Flags sticky, reset to zero, set wins over clear.
`ifndef UDIRQ_PARAMS_SVH
`define UDIRQ_PARAMS_SVH

`define UDIRQ_ADDR_FLAGS    4'h0
`define UDIRQ_ADDR_MASK     4'h4
`define UDIRQ_ADDR_ERREN    4'h8
`define UDIRQ_ADDR_ERRSTAT  4'hc
`define UDIRQ_ADDR_XFERSTAT 4'h1

`define UDIRQ_BIT_STALL  7
`define UDIRQ_BIT_RESUME 5
`define UDIRQ_BIT_IDLE   4
`define UDIRQ_BIT_TOKEN  3
`define UDIRQ_BIT_FRAME  2
`define UDIRQ_BIT_ERROR  1
`define UDIRQ_BIT_BUSRST 0

`define UDIRQ_CLEARABLE 16'h00bd
`define UDIRQ_FLAGS_RST 16'h0000
`define UDIRQ_MASK_RST  16'h0000

`define UDIRQ_CLK_PS    10000
`define UDIRQ_KSTATE_PS 2500000
`define UDIRQ_RESET_PS  2500000
`define UDIRQ_IDLE_MS   3
`define UDIRQ_KSTATE_CYC ((`UDIRQ_KSTATE_PS + `UDIRQ_CLK_PS - 1) / `UDIRQ_CLK_PS)
`define UDIRQ_RESET_CYC ((`UDIRQ_RESET_PS + `UDIRQ_CLK_PS - 1) / `UDIRQ_CLK_PS)
`define UDIRQ_IDLE_CYC  (`UDIRQ_IDLE_MS * 100000)

`define UDIRQ_FIFO_DEPTH 4
`define UDIRQ_FIFO_AW    2

`endif

// *** common/udirq_pkg.sv ***
// Types for the device interrupt status word block
package udirq_pkg;
    typedef logic [15:0] udirq_word_t;
    typedef logic [3:0]  udirq_addr_t;
    typedef logic [7:0]  udirq_stat_t;
    typedef enum logic [1:0] {
        LINE_SE0,
        LINE_J,
        LINE_K,
        LINE_SE1
    } udirq_line_t;
endpackage

// *** hw/udirq_stat_mem.sv ***
// Small memory holding transfer status entries
`timescale 1ns/1ps
module udirq_stat_mem
    import udirq_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        wrEn,
    input  wire logic [1:0]  wrAddr,
    input  wire udirq_stat_t wrData,
    input  wire logic [1:0]  rdAddr,
    output udirq_stat_t      rdData
);
    udirq_stat_t mem [0:3];

    // Registered read data
    always_ff @(posedge mclk)
    begin
        if (wrEn)
        begin
            mem[wrAddr] <= wrData;
        end
        rdData <= mem[rdAddr];
    end
endmodule

// *** hw/udirq_status.sv ***
// Device mode USB interrupt status word with timers and status FIFO
`timescale 1ns/1ps
`include "udirq_params.svh"
module udirq_status
(
    input  wire logic                 mclk,
    input  wire logic                 srst,
    input  wire udirq_pkg::udirq_addr_t regAddr,
    input  wire udirq_pkg::udirq_word_t regWdata,
    input  wire logic                 regWr,
    input  wire logic                 regRd,
    output udirq_pkg::udirq_word_t    regRdata,
    input  wire udirq_pkg::udirq_line_t lineState,
    input  wire logic                 lowSpeed,
    input  wire logic                 stallSent,
    input  wire logic                 tokenDone,
    input  wire udirq_pkg::udirq_stat_t tokenStat,
    input  wire logic                 sofSeen,
    input  wire logic                 sofThreshold,
    input  wire logic [7:0]           errEvents,
    output logic                      fifoFull,
    output logic                      irq
);
    import udirq_pkg::*;

    localparam int KCYC = `UDIRQ_KSTATE_CYC;
    localparam int RCYC = `UDIRQ_RESET_CYC;
    localparam int ICYC = `UDIRQ_IDLE_CYC;

    udirq_word_t flags_q, flags_d;
    udirq_word_t mask_q, mask_d;
    logic [7:0]  errEn_q, errEn_d;
    logic [7:0]  errStat_q, errStat_d;
    logic [8:0]  kCnt_q, kCnt_d;
    logic [8:0]  rCnt_q, rCnt_d;
    logic [18:0] iCnt_q, iCnt_d;
    logic        rstSeen_q, rstSeen_d;
    logic [1:0]  wp_q, wp_d, rp_q, rp_d;
    logic [2:0]  cnt_q, cnt_d;
    udirq_word_t rdata_q, rdata_d;
    logic        irq_q, irq_d;
    logic        full_q, full_d;
    udirq_stat_t memRd;
    logic        kState;
    logic        push;
    logic        pop;
    logic        wrFlags;
    udirq_word_t setV;
    udirq_word_t clrV;

    udirq_stat_mem uMem (
        .mclk   (mclk),
        .wrEn   (push),
        .wrAddr (wp_q),
        .wrData (tokenStat),
        .rdAddr (rp_d),
        .rdData (memRd)
    );

    always_comb
    begin
        kState = lowSpeed ? (lineState == LINE_J) : (lineState == LINE_K); // RULE_03
        wrFlags = regWr && (regAddr == `UDIRQ_ADDR_FLAGS);
        clrV = wrFlags ? (regWdata & `UDIRQ_CLEARABLE) : 16'h0000; // RULE_11
        push = tokenDone && (cnt_q != 3'(`UDIRQ_FIFO_DEPTH));
        pop = clrV[`UDIRQ_BIT_TOKEN] && flags_q[`UDIRQ_BIT_TOKEN]
            && (cnt_q != 3'h0); // RULE_06

        kCnt_d = kState ? ((kCnt_q < 9'(KCYC)) ? kCnt_q + 9'h1 : kCnt_q)
                        : 9'h000;
        rCnt_d = (lineState == LINE_SE0)
               ? ((rCnt_q < 9'(RCYC)) ? rCnt_q + 9'h1 : rCnt_q) : 9'h000;
        iCnt_d = (lineState == LINE_J)
               ? ((iCnt_q < 19'(ICYC)) ? iCnt_q + 19'h1 : iCnt_q) : 19'h0;
        rstSeen_d = (lineState == LINE_SE0) && (rstSeen_q
                  || (rCnt_q == 9'(RCYC - 1))); // RULE_10

        setV = 16'h0000;
        setV[`UDIRQ_BIT_STALL]  = stallSent; // RULE_01
        setV[`UDIRQ_BIT_RESUME] = kState && (kCnt_q == 9'(KCYC - 1)); // RULE_02
        setV[`UDIRQ_BIT_IDLE]   = (lineState == LINE_J)
                                && (iCnt_q == 19'(ICYC - 1)); // RULE_04
        setV[`UDIRQ_BIT_TOKEN]  = push || (cnt_q > 3'h1)
                                || (cnt_q == 3'h1 && !pop); // RULE_05
        setV[`UDIRQ_BIT_FRAME]  = sofSeen || sofThreshold; // RULE_07
        setV[`UDIRQ_BIT_BUSRST] = (lineState == LINE_SE0) && !rstSeen_q
                                && (rCnt_q == 9'(RCYC - 1)); // RULE_09

        errEn_d = errEn_q;
        errStat_d = errStat_q | (errEvents & errEn_q);
        mask_d = mask_q;
        if (regWr && regAddr == `UDIRQ_ADDR_ERREN)
        begin
            errEn_d = regWdata[7:0];
        end
        if (regWr && regAddr == `UDIRQ_ADDR_ERRSTAT)
        begin
            errStat_d = (errStat_q & ~regWdata[7:0]) | (errEvents & errEn_q);
        end
        if (regWr && regAddr == `UDIRQ_ADDR_MASK)
        begin
            mask_d = regWdata & (`UDIRQ_CLEARABLE | 16'h0002);
        end

        flags_d = ((flags_q & ~clrV) | setV) & `UDIRQ_CLEARABLE; // RULE_14
        flags_d[`UDIRQ_BIT_ERROR] = |(errStat_q & errEn_q); // RULE_08
        flags_d[15:8] = 8'h00; // RULE_13
        flags_d[6] = 1'b0; // RULE_13

        wp_d = push ? wp_q + 2'h1 : wp_q;
        rp_d = pop ? rp_q + 2'h1 : rp_q;
        cnt_d = cnt_q + (push ? 3'h1 : 3'h0) - (pop ? 3'h1 : 3'h0);
        full_d = (cnt_d == 3'(`UDIRQ_FIFO_DEPTH));
        irq_d = |(flags_d & mask_q);

        rdata_d = 16'h0000;
        if (regRd)
        begin
            case (regAddr)
                `UDIRQ_ADDR_FLAGS:    rdata_d = flags_q;
                `UDIRQ_ADDR_MASK:     rdata_d = mask_q;
                `UDIRQ_ADDR_ERREN:    rdata_d = {8'h00, errEn_q};
                `UDIRQ_ADDR_ERRSTAT:  rdata_d = {8'h00, errStat_q};
                `UDIRQ_ADDR_XFERSTAT: rdata_d = {8'h00, memRd};
                default:              rdata_d = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            flags_q   <= `UDIRQ_FLAGS_RST;
            mask_q    <= `UDIRQ_MASK_RST;
            errEn_q   <= 8'h00;
            errStat_q <= 8'h00;
            kCnt_q    <= 9'h000;
            rCnt_q    <= 9'h000;
            iCnt_q    <= 19'h0;
            rstSeen_q <= 1'b0;
            wp_q      <= 2'h0;
            rp_q      <= 2'h0;
            cnt_q     <= 3'h0;
            rdata_q   <= 16'h0000;
            irq_q     <= 1'b0;
            full_q    <= 1'b0;
        end
        else
        begin
            flags_q   <= flags_d;
            mask_q    <= mask_d;
            errEn_q   <= errEn_d;
            errStat_q <= errStat_d;
            kCnt_q    <= kCnt_d;
            rCnt_q    <= rCnt_d;
            iCnt_q    <= iCnt_d;
            rstSeen_q <= rstSeen_d;
            wp_q      <= wp_d;
            rp_q      <= rp_d;
            cnt_q     <= cnt_d;
            rdata_q   <= rdata_d;
            irq_q     <= irq_d;
            full_q    <= full_d;
        end
    end

    assign regRdata = rdata_q;
    assign irq = irq_q;
    assign fifoFull = full_q;
endmodule

// *** verification/tb_udirq_status.sv ***
// Testbench for the device interrupt status word
`timescale 1ns/1ps
module tb_udirq_status;
    import udirq_pkg::*;
    logic        mclk = 1'b0, srst = 1'b1, regWr = 1'b0, regRd = 1'b0;
    logic        lowSpeed = 1'b0, fifoFull, irq;
    logic [3:0]  ev = 4'h0;
    logic [1:0]  req = 2'd0;
    logic [7:0]  errEvents = 8'h00;
    udirq_addr_t regAddr = 4'h0;
    udirq_word_t regWdata = 16'h0000, regRdata;
    udirq_stat_t tokenStat = 8'h00;
    udirq_line_t lineState;
    int          n_fail = 0, compares = 0;
    always #5 mclk = ~mclk;
    udirq_status DUT (.mclk, .srst, .regAddr, .regWdata, .regWr, .regRd,
        .regRdata, .lineState, .lowSpeed, .stallSent(ev[3]),
        .tokenDone(ev[2]), .tokenStat, .sofSeen(ev[1]),
        .sofThreshold(ev[0]), .errEvents, .fifoFull, .irq);
    udirq_host_model host (.mclk, .req, .lowSpeed, .lineState);
    task automatic check(input string n, input udirq_word_t s, e);
        compares++;
        if (s !== e)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input udirq_addr_t a, input udirq_word_t d);
        @(posedge mclk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge mclk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input udirq_addr_t a, input udirq_word_t m, e);
        @(posedge mclk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge mclk);
        regRd <= 1'b0;
        #1 check("regRdata", regRdata & m, e);
    endtask
    task automatic pulse(input logic [3:0] w, input logic [7:0] e);
        @(posedge mclk);
        ev <= w;
        errEvents <= e;
        @(posedge mclk);
        ev <= 4'h0;
        errEvents <= 8'h00;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic end_sim;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        idle(10);
        srst <= 1'b0;
        rd(4'h0, 16'hffff, 16'h0000);
        rd(4'h4, 16'hffff, 16'h0000);
        tokenStat <= 8'h11;
        pulse(4'hc, 8'h00);
        tokenStat <= 8'h22;
        pulse(4'h6, 8'h00);
        rd(4'h0, 16'hffff, 16'h008c);
        wr(4'h0, 16'h0084);
        rd(4'h0, 16'hffff, 16'h0008);
        pulse(4'h1, 8'h00);
        rd(4'h0, 16'h0004, 16'h0004);
        rd(4'h1, 16'h00ff, 16'h0011);
        wr(4'h0, 16'h0008);
        rd(4'h1, 16'h00ff, 16'h0022);
        rd(4'h0, 16'h0008, 16'h0008);
        wr(4'h0, 16'h0008);
        rd(4'h0, 16'h0008, 16'h0000);
        pulse(4'h0, 8'h01);
        rd(4'h0, 16'h0002, 16'h0000);
        wr(4'h8, 16'h0001);
        pulse(4'h0, 8'h01);
        wr(4'h0, 16'h0002);
        rd(4'h0, 16'h0002, 16'h0002);
        wr(4'h4, 16'h0080);
        pulse(4'h8, 8'h00);
        rd(4'h0, 16'h0080, 16'h0080);
        idle(2);
        check("irq", {15'h0, irq}, 16'h0001);
        wr(4'h0, 16'h0080);
        pulse(4'h4, 8'h00);
        idle(2);
        check("irq", {15'h0, irq}, 16'h0000);
        repeat (3) pulse(4'h4, 8'h00);
        idle(2);
        check("fifoFull", {15'h0, fifoFull}, 16'h0001);
        for (int s = 0; s < 2; s++)
        begin
            lowSpeed <= s[0];
            wr(4'h0, 16'h0020);
            req <= 2'd2;
            idle(100);
            req <= 2'd0;
            rd(4'h0, 16'h0020, 16'h0000);
            req <= 2'd2;
            idle(262);
            rd(4'h0, 16'h0020, 16'h0020);
            req <= 2'd0;
        end
        lowSpeed <= 1'b0;
        req <= 2'd1;
        idle(262);
        rd(4'h0, 16'h0001, 16'h0001);
        wr(4'h0, 16'h0001);
        idle(10);
        req <= 2'd0;
        rd(4'h0, 16'h0001, 16'h0000);
        req <= 2'd1;
        idle(262);
        req <= 2'd0;
        rd(4'h0, 16'h0001, 16'h0001);
        wr(4'h2, 16'hffff);
        rd(4'h2, 16'hffff, 16'h0000);
        end_sim;
    end
endmodule

// *** verification/udirq_host_model.sv ***
// USB host model driving the bus line state
`timescale 1ns/1ps
module udirq_host_model
(
    input  wire logic             mclk,
    input  wire logic [1:0]       req,
    input  wire logic             lowSpeed,
    output udirq_pkg::udirq_line_t lineState
);
    import udirq_pkg::*;
    udirq_line_t lineD;
    always_comb
    begin
        lineD = lowSpeed ? LINE_K : LINE_J;
        if (req == 2'd1)
            lineD = LINE_SE0;
        if (req == 2'd2)
            lineD = lowSpeed ? LINE_J : LINE_K;
    end
    always_ff @(posedge mclk)
        lineState <= lineD;
endmodule

// *** verification/udirq_status_props.sv ***
// Checker for the device interrupt status word
`timescale 1ns/1ps
module udirq_status_props
(
    input wire logic                   mclk,
    input wire logic                   srst,
    input wire udirq_pkg::udirq_addr_t regAddr,
    input wire logic                   regWr,
    input wire udirq_pkg::udirq_word_t regWdata,
    input wire logic                   regRd,
    input wire udirq_pkg::udirq_word_t regRdata,
    input wire udirq_pkg::udirq_line_t lineState,
    input wire logic                   lowSpeed,
    input wire logic                   stallSent,
    input wire logic                   tokenDone,
    input wire logic                   sofSeen,
    input wire logic                   sofThreshold,
    input wire logic                   irq
);
    import udirq_pkg::*;
    logic [8:0] kCnt_q;
    logic [8:0] rstCnt_q;
    wire        rdF = regRd && regAddr == 4'h0;
    wire        isK = lineState == (lowSpeed ? LINE_J : LINE_K);
    wire        clrK = regWr && regAddr == 4'h0 && regWdata[5];
    wire        clrR = regWr && regAddr == 4'h0 && regWdata[0];
    // All ones marks a condition already cleared, or held for 511 cycles
    always_ff @(posedge mclk)
    begin
        kCnt_q   <= (srst || !isK) ? 9'h000
                    : (clrK || &kCnt_q) ? 9'h1ff : kCnt_q + 9'h001;
        rstCnt_q <= (srst || lineState != LINE_SE0) ? 9'h000
                    : (clrR || &rstCnt_q) ? 9'h1ff : rstCnt_q + 9'h001;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    // Reads below assume no clear was written while the condition held
    property p_quiet; regRdata != 16'h0000 |-> $past(regRd); endproperty
    property p_unimpl;
        $past(rdF) |-> regRdata[15:8] == 8'h00 && !regRdata[6];
    endproperty
    property p_stall;
        rdF && ($past(stallSent) || $past(stallSent, 2)) |=> regRdata[7];
    endproperty
    property p_token;
        rdF && ($past(tokenDone) || $past(tokenDone, 2)) |=> regRdata[3];
    endproperty
    property p_frame;
        rdF && ($past(sofSeen || sofThreshold)
            || $past(sofSeen || sofThreshold, 2)) |=> regRdata[2];
    endproperty
    property p_resume;
        rdF && kCnt_q > 9'd252 && !(&kCnt_q) |=> regRdata[5];
    endproperty
    property p_busrst;
        rdF && rstCnt_q > 9'd252 && !(&rstCnt_q) |=> regRdata[0];
    endproperty
    property p_reset; $fell(srst) |-> regRdata == 16'h0000 && !irq; endproperty
    property p_unmap; regRd && regAddr == 4'h2 |=> regRdata == 16'h0000;
    endproperty
    a_quiet: assert property (p_quiet) else $error("stray read data");
    a_unimpl: assert property (p_unimpl) else $error("unused bits set");
    a_stall: assert property (p_stall) else $error("stall flag");
    a_token: assert property (p_token) else $error("token flag");
    a_frame: assert property (p_frame) else $error("frame flag");
    a_resume: assert property (p_resume) else $error("resume flag");
    a_busrst: assert property (p_busrst) else $error("reset flag");
    a_reset: assert property (p_reset) else $error("reset values");
    a_unmap: assert property (p_unmap) else $error("unmapped read");
    c_resume: cover property (rdF && kCnt_q > 9'd252);
    c_busrst: cover property (rdF && rstCnt_q > 9'd252);
    c_irq: cover property ($rose(irq));
endmodule
bind udirq_status udirq_status_props u_props (.mclk, .srst, .regAddr,
    .regWr, .regWdata,
    .regRd, .regRdata, .lineState, .lowSpeed, .stallSent, .tokenDone,
    .sofSeen, .sofThreshold, .irq);
